// >>> hw/spi_master_slave_core.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// [RQ1] bytes shift msb first in both directions
// [RQ2] only master starts; slave answers on miso under master's clock
// [RQ3] both ends must use the same polarity and phase
// [RQ4] soft select manage replaces select pin by soft select level
// [RQ5] in master mode internal select must stay high
// [RQ6] phase 1 samples on second edge, phase 0 on first
// [RQ7] slave with phase 1 keeps select low through the transfer
// [RQ8] slave phase 0: select high between bytes, else write collides
// [RQ9] master drives sck with software rate, polarity and phase
// [RQ10] six master rates, fastest cpu clock over four
// [RQ11] external master clock at most cpu clock over two
// [RQ12] master and enable bits stay set only while select is high
// [RQ13] software writes status before setting master and enable
// [RQ14] master data write loads shifter and starts the byte
// [RQ15] completion sets done flag; irq only if enabled and unmasked
// [RQ16] master: done clears by status access then data read
// [RQ17] slave: done clears by status access then data read or write
// [RQ18] data writes dropped while done set until status read
// [RQ19] slave data write loads shifter, sent msb first on miso
// [RQ20] slave byte begins on master's first clock edge
// [RQ21] software clears done before the next byte ends
// [RQ22] slave setup: polarity, phase, select, then enable as slave
// [RQ23] master select pin low: mode fault, drop enable and master
// [RQ24] byte ending with done set: overrun, keep first byte
// [RQ25] data write during a transfer ignored, collision flag set
// [RQ26] polarity and phase pick the capture edge
// [RQ27] idle master sck rests at the polarity level
// [RQ28] rates are fixed divisions, smallest four
module spi_master_slave_core (
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // configuration levels
    input  wire logic        I_CLOCK_POLARITY,
    input  wire logic        I_CLOCK_PHASE,
    input  wire logic [2:0]  I_RATE_SELECT,
    input  wire logic        I_SOFT_SELECT_MANAGE,
    input  wire logic        I_SOFT_SELECT_LEVEL,
    input  wire logic        I_TRANSFER_IRQ_ENABLE,
    input  wire logic        I_CPU_IRQ_MASK,
    // control register write
    input  wire logic        I_CR_WR,
    input  wire logic        I_CR_MASTER_SELECT,
    input  wire logic        I_CR_PERIPHERAL_ENABLE,
    // status and data accesses
    input  wire logic        I_CSR_ACCESS,
    input  wire logic        I_DR_WR,
    input  wire logic [7:0]  I_DR_WDATA,
    input  wire logic        I_DR_RD,
    // serial pins
    input  wire logic        I_SCK,
    output logic             O_SCK,
    output logic             O_SCK_OE,
    input  wire logic        I_MOSI,
    output logic             O_MOSI,
    output logic             O_MOSI_OE,
    input  wire logic        I_MISO,
    output logic             O_MISO,
    output logic             O_MISO_OE,
    input  wire logic        I_SS_N,
    // status
    output logic [7:0]       O_DR_RDATA,
    output logic             O_MASTER_SELECT,
    output logic             O_PERIPHERAL_ENABLE,
    output logic             O_TRANSFER_DONE_FLAG,
    output logic             O_OVERRUN_FLAG,
    output logic             O_WRITE_COLLISION_FLAG,
    output logic             O_MODE_FAULT_FLAG,
    output logic             O_BUSY,
    output logic             O_IRQ
);
    typedef struct packed {
        spi_core_pkg::xfer_state_t state;
        logic                      master_select;
        logic                      peripheral_enable;
        logic                      transfer_done_flag;
        logic                      transfer_done_flag_arm;
        logic                      overrun_flag;
        logic                      write_collision_flag;
        logic                      write_collision_flag_arm;
        logic                      mode_fault_flag;
        logic                      mode_fault_flag_arm;
        logic                      sck_act;
        logic                      sck_prev;
        logic                      out;
        logic [3:0]                edge_cnt;
        logic [7:0]                tx_sh;
        logic [7:0]                rx_sh;
        logic [7:0]                rx_buf;
    } core_state_t;

    core_state_t st_q;
    core_state_t st_d;
    logic        ss_int;
    logic        tick;
    logic        master_run;
    logic        slave_en;
    logic        s_act;
    logic        ev;
    logic        lead;
    logic        proc;
    logic        drive;
    logic        done;
    logic        coll;
    logic        blocked;
    logic        wr_ok;
    logic        in_bit;
    logic [7:0]  rx_next;

    spi_rate_gen u_rate (
        .i_clk  (I_CLK),
        .i_rst  (I_RST),
        .i_run  (master_run),
        .i_rate (I_RATE_SELECT),
        .o_tick (tick)
    );

    always_comb begin
        ss_int     = I_SOFT_SELECT_MANAGE ? I_SOFT_SELECT_LEVEL : I_SS_N; // [RQ4]
        master_run = st_q.master_select && st_q.peripheral_enable && (st_q.state == spi_core_pkg::ST_SHIFT);
        slave_en   = st_q.peripheral_enable && !st_q.master_select && !ss_int;
        s_act      = I_SCK ^ I_CLOCK_POLARITY; // [RQ3]
        in_bit     = st_q.master_select ? I_MISO : I_MOSI;
        // master edges come from the divider, slave edges from the pin
        ev         = st_q.master_select ? (master_run && tick) : (slave_en && (s_act != st_q.sck_prev));
        lead       = st_q.master_select ? !st_q.sck_act : s_act;
        // a slave byte opens on the first leading edge seen while selected
        proc       = ev && ((st_q.state == spi_core_pkg::ST_SHIFT)
                     || (!st_q.master_select && lead)); // [RQ20]
        drive      = (lead == I_CLOCK_PHASE); // [RQ6] [RQ26]
        done       = proc && (st_q.edge_cnt == spi_core_pkg::LAST_EDGE);
        rx_next    = (proc && !drive) ? {st_q.rx_sh[6:0], in_bit} : st_q.rx_sh; // [RQ1]
        // phase 0 slave must see select high between bytes to load
        coll       = (st_q.state == spi_core_pkg::ST_SHIFT)
                     || (!st_q.master_select && st_q.peripheral_enable && !I_CLOCK_PHASE && !ss_int); // [RQ8] [RQ25]
        blocked    = st_q.transfer_done_flag && !st_q.transfer_done_flag_arm && !I_CSR_ACCESS; // [RQ18]
        wr_ok      = I_DR_WR && !blocked && !coll;

        st_d          = st_q;
        st_d.sck_prev = s_act;
        st_d.rx_sh    = rx_next;

        // shifting engine
        if (proc) begin
            st_d.state    = spi_core_pkg::ST_SHIFT;
            st_d.edge_cnt = st_q.edge_cnt + 4'h1;
            if (st_q.master_select) begin
                st_d.sck_act = !st_q.sck_act; // [RQ9]
            end
            if (drive && !(I_CLOCK_PHASE == 1'b0 && done)) begin
                st_d.out   = st_q.tx_sh[7]; // [RQ1] [RQ19]
                st_d.tx_sh = {st_q.tx_sh[6:0], 1'b0};
            end
            if (done) begin
                st_d.state    = spi_core_pkg::ST_IDLE;
                st_d.edge_cnt = spi_core_pkg::EDGE_RST;
            end
        end
        // deselect aborts a slave byte mid-way
        if (!st_q.master_select && (ss_int || !st_q.peripheral_enable)) begin
            st_d.state    = spi_core_pkg::ST_IDLE;
            st_d.edge_cnt = spi_core_pkg::EDGE_RST;
        end

        // status access arms the two-step clears; overrun clears at once
        if (I_CSR_ACCESS) begin
            st_d.transfer_done_flag_arm = st_q.transfer_done_flag_arm || st_q.transfer_done_flag;
            st_d.write_collision_flag_arm = st_q.write_collision_flag_arm || st_q.write_collision_flag;
            st_d.mode_fault_flag_arm = st_q.mode_fault_flag_arm || st_q.mode_fault_flag;
            st_d.overrun_flag      = 1'b0; // [RQ24]
        end
        if (st_q.transfer_done_flag_arm && (I_DR_RD || (I_DR_WR && !st_q.master_select))) begin
            st_d.transfer_done_flag     = 1'b0; // [RQ16] [RQ17]
            st_d.transfer_done_flag_arm = 1'b0;
        end
        if (st_q.write_collision_flag_arm && I_DR_RD) begin
            st_d.write_collision_flag     = 1'b0;
            st_d.write_collision_flag_arm = 1'b0;
        end

        // data register write
        if (I_DR_WR && coll) begin
            st_d.write_collision_flag = 1'b1; // [RQ25]
        end
        if (wr_ok) begin
            if (I_CLOCK_PHASE) begin
                st_d.tx_sh = I_DR_WDATA;
            end else begin
                st_d.out   = I_DR_WDATA[7];
                st_d.tx_sh = {I_DR_WDATA[6:0], 1'b0};
            end
            if (st_q.master_select && st_q.peripheral_enable) begin
                st_d.state    = spi_core_pkg::ST_SHIFT; // [RQ14]
                st_d.edge_cnt = spi_core_pkg::EDGE_RST;
                st_d.sck_act  = 1'b0;
                st_d.rx_sh    = spi_core_pkg::DATA_RST;
            end
        end

        // completion: set wins over any clear in the same cycle
        if (done) begin
            if (st_q.transfer_done_flag) begin
                st_d.overrun_flag  = 1'b1; // [RQ24]
                st_d.transfer_done_flag = 1'b1;
            end else begin
                st_d.transfer_done_flag   = 1'b1; // [RQ15]
                st_d.rx_buf = rx_next;
            end
        end

        // control register write; enable bits refused while fault unacknowledged
        if (I_CR_WR) begin
            if (!st_q.mode_fault_flag || st_q.mode_fault_flag_arm) begin
                st_d.master_select     = I_CR_MASTER_SELECT;
                st_d.peripheral_enable      = I_CR_PERIPHERAL_ENABLE;
                st_d.mode_fault_flag     = 1'b0;
                st_d.mode_fault_flag_arm = 1'b0;
            end else begin
                st_d.master_select = 1'b0;
                st_d.peripheral_enable  = 1'b0;
            end
            if (I_CR_MASTER_SELECT != st_q.master_select || !I_CR_PERIPHERAL_ENABLE) begin
                st_d.state    = spi_core_pkg::ST_IDLE;
                st_d.edge_cnt = spi_core_pkg::EDGE_RST;
                st_d.sck_act  = 1'b0;
            end
        end
        // master seeing select low falls back to disabled slave
        if (st_q.master_select && st_q.peripheral_enable && !ss_int) begin
            st_d.mode_fault_flag     = 1'b1; // [RQ23] [RQ12]
            st_d.master_select     = 1'b0;
            st_d.peripheral_enable      = 1'b0;
            st_d.state    = spi_core_pkg::ST_IDLE;
            st_d.edge_cnt = spi_core_pkg::EDGE_RST;
            st_d.sck_act  = 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            st_q <= '{state: spi_core_pkg::ST_IDLE, edge_cnt: spi_core_pkg::EDGE_RST,
                      tx_sh: spi_core_pkg::DATA_RST, rx_sh: spi_core_pkg::DATA_RST,
                      rx_buf: spi_core_pkg::DATA_RST, default: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    always_comb begin
        O_SCK                  = I_CLOCK_POLARITY ^ st_q.sck_act; // [RQ27]
        O_SCK_OE               = st_q.master_select && st_q.peripheral_enable; // [RQ9]
        O_MOSI                 = st_q.out;
        O_MOSI_OE              = st_q.master_select && st_q.peripheral_enable;
        O_MISO                 = st_q.out; // [RQ19]
        O_MISO_OE              = slave_en; // [RQ2]
        O_DR_RDATA             = st_q.rx_buf;
        O_MASTER_SELECT        = st_q.master_select;
        O_PERIPHERAL_ENABLE    = st_q.peripheral_enable;
        O_TRANSFER_DONE_FLAG   = st_q.transfer_done_flag;
        O_OVERRUN_FLAG         = st_q.overrun_flag;
        O_WRITE_COLLISION_FLAG = st_q.write_collision_flag;
        O_MODE_FAULT_FLAG      = st_q.mode_fault_flag;
        O_BUSY                 = st_q.state == spi_core_pkg::ST_SHIFT;
        // collision is status only and never interrupts
        O_IRQ                  = I_TRANSFER_IRQ_ENABLE && !I_CPU_IRQ_MASK
                                 && (st_q.transfer_done_flag || st_q.overrun_flag || st_q.mode_fault_flag); // [RQ15]
    end

    AST_IRQ_GATE: assert property (@(posedge I_CLK) disable iff (I_RST) // [RQ15]
        O_IRQ |-> I_TRANSFER_IRQ_ENABLE && !I_CPU_IRQ_MASK)
        else $error("irq raised while disabled or masked");
    AST_TRANSFER_DONE_FLAG_SET: assert property (@(posedge I_CLK) disable iff (I_RST) // [RQ15]
        (done && !st_q.transfer_done_flag) |=> st_q.transfer_done_flag && (st_q.rx_buf == $past(rx_next)))
        else $error("completion did not set done flag with data");
    AST_OVERRUN: assert property (@(posedge I_CLK) disable iff (I_RST) // [RQ24]
        (done && st_q.transfer_done_flag) |=> st_q.overrun_flag && $stable(st_q.rx_buf))
        else $error("overrun lost or buffer overwritten");
    AST_MODE_FAULT: assert property (@(posedge I_CLK) disable iff (I_RST) // [RQ23]
        (st_q.master_select && st_q.peripheral_enable && !ss_int) |=> st_q.mode_fault_flag && !st_q.master_select && !st_q.peripheral_enable)
        else $error("mode fault not taken");
    AST_SCK_IDLE: assert property (@(posedge I_CLK) disable iff (I_RST) // [RQ27]
        (O_SCK_OE && st_q.state == spi_core_pkg::ST_IDLE) |-> O_SCK == I_CLOCK_POLARITY)
        else $error("idle sck not at polarity level");
    AST_COLLISION: assert property (@(posedge I_CLK) disable iff (I_RST) // [RQ25]
        (I_DR_WR && st_q.state == spi_core_pkg::ST_SHIFT) |=> st_q.write_collision_flag
        && (st_q.edge_cnt == $past(st_q.edge_cnt)
        || st_q.edge_cnt == $past(st_q.edge_cnt) + 4'h1
        || st_q.state == spi_core_pkg::ST_IDLE))
        else $error("write during transfer not flagged");
    AST_WRITE_BLOCK: assert property (@(posedge I_CLK) disable iff (I_RST) // [RQ18]
        (I_DR_WR && st_q.transfer_done_flag && !st_q.transfer_done_flag_arm && !I_CSR_ACCESS && st_q.master_select && st_q.peripheral_enable
        && st_q.state == spi_core_pkg::ST_IDLE)
        |=> $stable(st_q.tx_sh) && $stable(st_q.state))
        else $error("data write accepted while done flag pending");
    AST_TRANSFER_DONE_FLAG_HOLD: assert property (@(posedge I_CLK) disable iff (I_RST) // [RQ16]
        (st_q.master_select && st_q.transfer_done_flag && !I_DR_RD) |=> st_q.transfer_done_flag)
        else $error("master done flag cleared without data read");
    AST_MSB_FIRST: assert property (@(posedge I_CLK) disable iff (I_RST) // [RQ1]
        (wr_ok && st_q.master_select && st_q.peripheral_enable && !I_CLOCK_PHASE) |=> O_MOSI == $past(I_DR_WDATA[7]))
        else $error("first bit on mosi is not the msb");
endmodule : spi_master_slave_core
`default_nettype wire

// >>> hw/spi_core_pkg.sv
package spi_core_pkg;
    // rate field and half-period counter
    localparam int         RATE_W     = 3;
    localparam int         HALF_W     = 7;
    localparam int         RATE_COUNT = 6;
    // half periods in cpu cycles for rate settings 0..5 (divide by 4..128)
    localparam logic [6:0] RATE_HALF [0:5] = '{7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40};
    // sixteen clock edges make one byte
    localparam logic [3:0] LAST_EDGE  = 4'hf;
    localparam logic [3:0] EDGE_RST   = 4'h0;
    localparam logic [7:0] DATA_RST   = 8'h00;
    localparam logic [6:0] HALF_RST   = 7'h00;

    typedef enum logic {
        ST_IDLE,
        ST_SHIFT
    } xfer_state_t;
endpackage : spi_core_pkg

// >>> hw/spi_rate_gen.sv
`timescale 1ns/1ns
`default_nettype none
module spi_rate_gen (
    // clock and reset
    input  wire logic                           i_clk,
    input  wire logic                           i_rst,
    // control
    input  wire logic                           i_run,
    input  wire logic [spi_core_pkg::RATE_W-1:0] i_rate,
    // half-period enable
    output logic                                o_tick
);
    typedef struct packed {
        logic [spi_core_pkg::HALF_W-1:0] cnt;
    } gen_state_t;

    gen_state_t                      st_q;
    gen_state_t                      st_d;
    logic [spi_core_pkg::HALF_W-1:0] half;

    // codes 6 and 7 fall back to the slowest rate
    function automatic logic [spi_core_pkg::HALF_W-1:0] half_of(
        input logic [spi_core_pkg::RATE_W-1:0] rate
    );
        if (32'(rate) < spi_core_pkg::RATE_COUNT) begin
            half_of = spi_core_pkg::RATE_HALF[rate];
        end else begin
            half_of = spi_core_pkg::RATE_HALF[spi_core_pkg::RATE_COUNT-1];
        end
    endfunction : half_of

    always_comb begin
        half   = half_of(i_rate); // [RQ10] [RQ28]
        st_d   = st_q;
        o_tick = 1'b0;
        if (!i_run) begin
            st_d.cnt = spi_core_pkg::HALF_RST;
        end else if (st_q.cnt == half - 7'h01) begin
            st_d.cnt = spi_core_pkg::HALF_RST;
            o_tick   = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 7'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q.cnt <= spi_core_pkg::HALF_RST;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : spi_rate_gen
`default_nettype wire

// >>> tb/spi_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module spi_far_end (
    // clock
    input  wire logic       i_clk,
    // mode, same polarity and phase as the core
    input  wire logic       i_clock_polarity,
    input  wire logic       i_clock_phase,
    input  wire logic       i_as_master,
    // byte load, starts the clock when master
    input  wire logic       i_load,
    input  wire logic [7:0] i_tx,
    // serial lines
    input  wire logic       i_sck,
    input  wire logic       i_din,
    output logic            o_sck,
    output logic            o_dout,
    output logic [7:0]      o_rx
);
    // two cycles a half period: cpu/4, inside the cpu/2 ceiling
    localparam int HALF = 2;
    logic [7:0] tx_q = 8'h00;
    logic [4:0] cnt_q = 5'h10;
    logic       tog_q = 1'b0;
    logic       seen_q = 1'b0;
    logic       run_q = 1'b0;
    logic       rel_q = 1'b1;
    int         tmr = 0;
    logic       edge_now;
    logic [4:0] idx;

    // only the master makes clock edges
    assign edge_now = i_as_master ? (run_q && tmr == HALF - 1) : (i_sck != seen_q);
    // phase 1 moves data on leading edges, phase 0 on trailing
    assign idx = (i_clock_phase && cnt_q != 5'h00) ? (cnt_q - 5'h01) >> 1 : cnt_q >> 1;
    // msb first; last bit holds one cycle past the final edge, then lets go
    assign o_dout = (cnt_q == 5'h10) ? (rel_q ? ~tx_q[0] : tx_q[0]) : tx_q[3'h7 - idx[2:0]];
    // clock stands at the idle level outside frames
    assign o_sck = i_clock_polarity ^ tog_q;

    always @(posedge i_clk) begin
        seen_q <= i_sck;
        rel_q <= cnt_q == 5'h10;
        if (i_load) begin
            tx_q <= i_tx;
            cnt_q <= 5'h00;
            tog_q <= 1'b0;
            run_q <= i_as_master;
            tmr <= 0;
        end else if (edge_now && cnt_q < 5'h10) begin
            cnt_q <= cnt_q + 5'h01;
            tog_q <= ~tog_q;
            tmr <= 0;
            run_q <= run_q && cnt_q != 5'h0f;
            if (cnt_q[0] == i_clock_phase) begin
                o_rx <= {o_rx[6:0], i_din};
            end
        end else if (run_q) begin
            tmr <= tmr + 1;
        end
    end
endmodule : spi_far_end
`default_nettype wire

// >>> tb/test_spi_master_slave_core.sv
`timescale 1ns/1ns
`default_nettype none
module test_spi_master_slave_core;
    localparam int CR = 0;
    localparam int CSR = 1;
    localparam int DW = 2;
    localparam int DRD = 3;
    localparam int LD = 4;
    logic       clk, rst, clock_polarity, clock_phase, soft_select_manage, ssl, irq_en, mask, ss_n;
    logic       cr_wr, cr_m, cr_e, csr_acc, dr_wr, dr_rd, p_master, p_load;
    logic [2:0] rate;
    logic [7:0] dr_wdata, rdata, p_rx;
    logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_sck, p_dout;
    logic       master_select, peripheral_enable, done, overrun_flag, write_collision_flag, mode_fault_flag, busy, irq;
    wire        sck_l = sck_oe ? sck_o : p_sck;
    wire        mosi_l = mosi_oe ? mosi_o : p_dout;
    wire        miso_l = miso_oe ? miso_o : p_dout;
    int         n_errors = 0;
    int         n_checks = 0;
    int         n;

    always #10 clk = ~clk;

    spi_master_slave_core i_dut (
        .I_CLK(clk), .I_RST(rst), .I_CLOCK_POLARITY(clock_polarity), .I_CLOCK_PHASE(clock_phase),
        .I_RATE_SELECT(rate), .I_SOFT_SELECT_MANAGE(soft_select_manage), .I_SOFT_SELECT_LEVEL(ssl),
        .I_TRANSFER_IRQ_ENABLE(irq_en), .I_CPU_IRQ_MASK(mask), .I_CR_WR(cr_wr),
        .I_CR_MASTER_SELECT(cr_m), .I_CR_PERIPHERAL_ENABLE(cr_e), .I_CSR_ACCESS(csr_acc),
        .I_DR_WR(dr_wr), .I_DR_WDATA(dr_wdata), .I_DR_RD(dr_rd), .I_SCK(sck_l),
        .O_SCK(sck_o), .O_SCK_OE(sck_oe), .I_MOSI(mosi_l), .O_MOSI(mosi_o),
        .O_MOSI_OE(mosi_oe), .I_MISO(miso_l), .O_MISO(miso_o), .O_MISO_OE(miso_oe),
        .I_SS_N(ss_n), .O_DR_RDATA(rdata), .O_MASTER_SELECT(master_select),
        .O_PERIPHERAL_ENABLE(peripheral_enable), .O_TRANSFER_DONE_FLAG(done), .O_OVERRUN_FLAG(overrun_flag),
        .O_WRITE_COLLISION_FLAG(write_collision_flag), .O_MODE_FAULT_FLAG(mode_fault_flag), .O_BUSY(busy), .O_IRQ(irq)
    );

    spi_far_end i_far (
        .i_clk(clk), .i_clock_polarity(clock_polarity), .i_clock_phase(clock_phase), .i_as_master(p_master),
        .i_load(p_load), .i_tx(dr_wdata), .i_sck(sck_l),
        .i_din(p_master ? miso_l : mosi_l), .o_sck(p_sck), .o_dout(p_dout), .o_rx(p_rx)
    );

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one-cycle strobe; the byte also feeds the far end and the control bits
    task automatic strobe(input int k, input logic [7:0] d);
        tick();
        dr_wdata = d;
        {cr_m, cr_e} = d[1:0];
        {p_load, dr_rd, dr_wr, csr_acc, cr_wr} = 5'h01 << k;
        tick();
        {p_load, dr_rd, dr_wr, csr_acc, cr_wr} = 5'h00;
    endtask : strobe

    // bounded wait: for the done flag, or counting busy cycles
    task automatic wait_on(input logic want_done);
        n = 0;
        while (want_done ? done !== 1'b1 : busy === 1'b1) begin
            tick();
            n++;
            if (n > 3000) begin
                n_errors++;
                close_out();
            end
        end
    endtask : wait_on

    initial begin
        {clk, clock_polarity, clock_phase, irq_en, mask, cr_wr, cr_m, cr_e, csr_acc, dr_wr, dr_rd} = '0;
        {p_master, p_load, rate, dr_wdata} = '0;
        {rst, soft_select_manage, ssl, ss_n} = 4'hf;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        tick();
        chk({sck_o, sck_oe, mosi_oe, miso_oe, done, overrun_flag, write_collision_flag, mode_fault_flag, master_select, peripheral_enable}, 16'h0);
        for (int m = 0; m < 4; m++) begin
            strobe(CR, 8'h00);
            {clock_polarity, clock_phase} = 2'(m);
            {irq_en, mask} = {1'b1, clock_phase};
            strobe(CR, 8'h03);
            chk({master_select, peripheral_enable}, 2'b11);
            strobe(LD, 8'h3c + 8'(m));
            strobe(DW, 8'ha5 ^ 8'(m));
            wait_on(1'b0);
            chk(16'(n), 16'd32);
            // far end sees the last edge one cycle late
            tick();
            chk(rdata, 8'h3c + 8'(m));
            chk(p_rx, 8'ha5 ^ 8'(m));
            chk({sck_o, done, irq}, {clock_polarity, 1'b1, ~mask});
            strobe(DW, 8'h00);
            chk(busy, 1'b0);
            strobe(CSR, 8'h00);
            strobe(DRD, 8'h00);
            chk(done, 1'b0);
        end
        // codes 6 and 7 run at the slowest rate
        for (int r = 1; r < 8; r++) begin
            rate = 3'(r);
            strobe(DW, 8'(r));
            wait_on(1'b0);
            chk(16'(n), 16'd8 << (r > 5 ? 7 : r + 2));
            strobe(CSR, 8'h00);
            strobe(DRD, 8'h00);
        end
        rate = 3'd0;
        strobe(LD, 8'h11);
        strobe(DW, 8'h96);
        strobe(DW, 8'h55);
        chk({write_collision_flag, busy}, 2'b11);
        wait_on(1'b0);
        tick();
        chk({rdata, p_rx}, 16'h1196);
        strobe(CSR, 8'h00);
        strobe(LD, 8'h77);
        strobe(DW, 8'h22);
        wait_on(1'b0);
        chk({overrun_flag, done, rdata}, {2'b11, 8'h11});
        strobe(CSR, 8'h00);
        chk(overrun_flag, 1'b0);
        strobe(DRD, 8'h00);
        chk({done, write_collision_flag}, 2'b00);
        {irq_en, mask, ss_n} = 3'b100;
        repeat (3) tick();
        chk(mode_fault_flag, 1'b0);
        ssl = 1'b0;
        repeat (3) tick();
        chk({mode_fault_flag, master_select, peripheral_enable, irq}, 4'b1001);
        {ssl, ss_n} = 2'b11;
        strobe(CSR, 8'h00);
        strobe(CR, 8'h03);
        chk({mode_fault_flag, master_select, peripheral_enable}, 3'b011);
        strobe(CR, 8'h00);
        {p_master, clock_polarity} = 2'b11;
        for (int m = 0; m < 2; m++) begin
            clock_phase = m[0];
            ssl = 1'b1;
            strobe(CR, 8'h01);
            strobe(DW, 8'hc3 ^ 8'(m));
            // select held low across the whole byte
            ssl = 1'b0;
            strobe(LD, 8'h5a ^ 8'(m));
            wait_on(1'b1);
            chk(rdata, 8'h5a ^ 8'(m));
            chk(p_rx, 8'hc3 ^ 8'(m));
            ssl = 1'b1;
            strobe(CSR, 8'h00);
            strobe(DW, 8'h00);
            chk(done, 1'b0);
            strobe(CR, 8'h00);
        end
        clock_phase = 1'b0;
        strobe(CR, 8'h01);
        ssl = 1'b0;
        strobe(DW, 8'h00);
        chk(write_collision_flag, 1'b1);
        close_out();
    end
endmodule : test_spi_master_slave_core
`default_nettype wire
